// ===== hdl/pfsl_pkg.sv
// Constants, flash map and state encoding for the power-fail state logger
package pfsl_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_HZ       = 50_000_000;
   localparam int unsigned CLK_KHZ      = CLK_HZ / 1000;
   localparam int unsigned BLINK_MS     = 500;
   localparam int unsigned DEBOUNCE_MS  = 10;
   localparam int unsigned BLINK_TOGGLES = 10;
   localparam int unsigned CNT_W        = 25;

   // ==========================================================
   // Data flash map
   localparam int unsigned FA_W         = 20;
   localparam int unsigned OFF_W        = 10;
   localparam logic [19:0] DF_BASE      = 20'hf1000;
   localparam logic [9:0]  OFF_VALID    = 10'h000;
   localparam logic [9:0]  OFF_INVALID  = 10'h001;
   localparam logic [9:0]  OFF_FIRST    = 10'h002;
   localparam logic [9:0]  OFF_LAST     = 10'h3fe;
   localparam logic [9:0]  UNIT_BYTES   = 10'h002;
   localparam logic        BLK_LAST     = 1'h1;
   localparam logic [7:0]  FLAG_SET     = 8'h00;
   localparam logic [7:0]  FLAG_CLR     = 8'hff;
   localparam logic [7:0]  REC_TERM     = 8'h00;

   // Record layout: target in upper nibble, remaining blinks in lower
   localparam int unsigned REC_TGT_LSB  = 4;
   localparam logic [3:0]  TGT_A        = 4'h0;
   localparam logic [3:0]  TGT_B        = 4'h1;

   // Flash commands
   localparam logic [1:0]  FC_READ      = 2'h0;
   localparam logic [1:0]  FC_WRITE     = 2'h1;
   localparam logic [1:0]  FC_BLANK     = 2'h2;
   localparam logic [1:0]  FC_ERASE     = 2'h3;

   // ==========================================================
   // APB registers
   localparam logic [7:0]  REG_CTRL     = 8'h00;
   localparam logic [7:0]  REG_STATUS   = 8'h04;
   localparam logic [7:0]  REG_WADDR    = 8'h08;
   localparam int unsigned CTRL_KEY     = 0;
   localparam int unsigned CTRL_HOLD    = 1;
   localparam logic [1:0]  CTRL_RST     = 2'h0;

   // ==========================================================
   // Controller states
   typedef enum logic [15:0] {
      S_OPEN   = 16'h0001,
      S_RDV    = 16'h0002,
      S_RDI    = 16'h0004,
      S_SCAN   = 16'h0008,
      S_RDREC  = 16'h0010,
      S_MKINV  = 16'h0020,
      S_FUV    = 16'h0040,
      S_FUI    = 16'h0080,
      S_ERASE  = 16'h0100,
      S_MKVAL  = 16'h0200,
      S_RUN    = 16'h0400,
      S_SVREC  = 16'h0800,
      S_SVTERM = 16'h1000,
      S_CLOSE  = 16'h2000,
      S_DONE   = 16'h4000,
      S_ERR    = 16'h8000
   } pfsl_state_t;

endpackage

// ===== hdl/pfsl_top.sv
// Power-fail state logger: blink controller, flash manager and APB registers
`timescale 1ns/1ps

// How it works
// - Ten toggles at 500 ms, then idle
// - New press blinks the other indicator
// - Presses ignored while blinking
// - Restore newest record after reset, resume; a record at OFF_LAST is not read before the block switch
// - Low voltage: save, light done, stop
// - Terminator 0x00 written after each record
// - Flash error: both indicators on, stop
// - Record: upper nibble target, lower remaining
// - Keypress qualified by 10 ms debounce
// - Prepare early; low-voltage phase only writes
// - 1-KB blocks, two flag bytes first
// - Block state decoded from two flags
// - Starting a block programs valid flag
// - Full block: mark invalid, erase another; with both blocks invalid, block 0 is erased even when it is the full one
// - Flags at first and second block byte
// - Never rewrite written byte without erase
// - Erase only during preparation phase
// - Flash access only between open, close
// - Backward 2-byte blank check finds newest
// - Writability by blank check, not FFH
module pfsl_top
   import pfsl_pkg::*;
#(
   parameter int unsigned BLINK_CYC = CLK_KHZ * BLINK_MS,
   parameter int unsigned DEB_CYC   = CLK_KHZ * DEBOUNCE_MS
) (
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        KEY_N,
   input  wire logic        LOW_VOLT,
   output logic             IND_A,
   output logic             IND_B,
   output logic             SAVE_DONE,
   output logic             STOP_MODE,
   output logic             FL_EN,
   output logic             FL_REQ,
   output logic [1:0]       FL_CMD,
   output logic [19:0]      FL_ADDR,
   output logic [7:0]       FL_WDATA,
   input  wire logic        FL_ACK,
   input  wire logic [7:0]  FL_RDATA,
   input  wire logic        FL_BLANK,
   input  wire logic        FL_ERR,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [31:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR
);

   // ==========================================================
   // Helpers
   function automatic logic is_flash_op(input pfsl_state_t s);
      is_flash_op = (s == S_RDV) || (s == S_RDI) || (s == S_SCAN) || (s == S_RDREC) ||
                    (s == S_MKINV) || (s == S_FUV) || (s == S_FUI) || (s == S_ERASE) ||
                    (s == S_MKVAL) || (s == S_SVREC) || (s == S_SVTERM);
   endfunction

   // Block state from flag pair: 1 valid, 2 unused, 3 invalid
   function automatic logic [1:0] blk_state(input logic [7:0] v, input logic [7:0] i);
      if (v == FLAG_SET && i == FLAG_CLR)
         blk_state = 2'h1;
      else if (v == FLAG_CLR && i == FLAG_CLR)
         blk_state = 2'h2;
      else if (v == FLAG_SET && i == FLAG_SET)
         blk_state = 2'h3;
      else
         blk_state = 2'h0;
   endfunction

   // ==========================================================
   // Input synchronisers
   logic [1:0] key_sync_reg;
   logic [1:0] lvd_sync_reg;
   logic       key_prev_reg;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         key_sync_reg <= 2'h3;
         lvd_sync_reg <= 2'h0;
         key_prev_reg <= 1'h1;
      end else begin
         key_sync_reg <= {key_sync_reg[0], KEY_N};
         lvd_sync_reg <= {lvd_sync_reg[0], LOW_VOLT};
         key_prev_reg <= key_sync_reg[1];
      end
   end

   wire key_n_s  = key_sync_reg[1];
   wire lvd_s    = lvd_sync_reg[1];
   wire key_fall = key_prev_reg & ~key_n_s;

   // ==========================================================
   // Registers
   pfsl_state_t       state_reg, state_next;
   logic              blk_reg, blk_next;
   logic [7:0]        flag_v_reg, flag_v_next;
   logic [OFF_W-1:0]  ptr_reg, ptr_next;
   logic [OFF_W-1:0]  wr_reg, wr_next;
   logic              fb_ok_reg, fb_ok_next;
   logic              fb_blk_reg, fb_blk_next;
   logic              req_reg;
   logic [1:0]        cmd_reg;
   logic [19:0]       addr_reg;
   logic [7:0]        wdata_reg;
   logic              en_reg;
   logic              run_reg;
   logic              tgt_reg;
   logic              last_tgt_reg;
   logic [3:0]        rem_reg;
   logic              ind_a_reg;
   logic              ind_b_reg;
   logic              done_reg;
   logic              stop_reg;
   logic [CNT_W-1:0]  blink_cnt_reg;
   logic [CNT_W-1:0]  deb_cnt_reg;
   logic              deb_busy_reg;
   logic [1:0]        ctrl_reg;
   logic              soft_key_reg;
   logic [31:0]       prdata_reg;
   logic              pready_reg;
   logic              pslverr_reg;

   // ==========================================================
   // Flash sequencer
   wire        fl_done   = req_reg & FL_ACK;
   wire        fl_ok     = fl_done & ~FL_ERR;
   wire [1:0]  rd_state  = blk_state(flag_v_reg, FL_RDATA);
   wire [7:0]  rec_byte  = run_reg ? {REC_TGT_LSB'({3'h0, tgt_reg}), rem_reg}
                                   : {REC_TGT_LSB'({3'h0, last_tgt_reg}), 4'h0};
   wire        restore   = (state_reg == S_RDREC) & fl_ok;
   wire [3:0]  rec_tgt   = FL_RDATA[7:REC_TGT_LSB];
   wire [3:0]  rec_rem   = FL_RDATA[REC_TGT_LSB-1:0];

   always_comb begin
      state_next  = state_reg;
      blk_next    = blk_reg;
      flag_v_next = flag_v_reg;
      ptr_next    = ptr_reg;
      wr_next     = wr_reg;
      fb_ok_next  = fb_ok_reg;
      fb_blk_next = fb_blk_reg;
      if (fl_done && FL_ERR) begin
         state_next = S_ERR;
      end else begin
         case (state_reg)
            S_OPEN: begin
               state_next = S_RDV;
            end
            S_RDV: if (fl_ok) begin
               flag_v_next = FL_RDATA;
               state_next  = S_RDI;
            end
            S_RDI: if (fl_ok) begin
               if (rd_state == 2'h1) begin
                  ptr_next   = OFF_LAST;
                  state_next = S_SCAN;
               end else if (blk_reg == BLK_LAST) begin
                  blk_next   = 1'h0;
                  fb_ok_next = 1'h0;
                  state_next = S_FUV;
               end else begin
                  blk_next   = ~blk_reg;
                  state_next = S_RDV;
               end
            end
            S_SCAN: if (fl_ok) begin
               if (!FL_BLANK) begin
                  if (ptr_reg == OFF_LAST) begin
                     state_next = S_MKINV;
                  end else begin
                     wr_next    = ptr_reg + UNIT_BYTES;
                     state_next = S_RDREC;
                  end
               end else if (ptr_reg == OFF_FIRST) begin
                  wr_next    = OFF_FIRST;
                  state_next = S_RUN;
               end else begin
                  ptr_next = ptr_reg - UNIT_BYTES;
               end
            end
            S_RDREC: if (fl_ok) begin
               state_next = S_RUN;
            end
            S_MKINV: if (fl_ok) begin
               blk_next   = 1'h0;
               fb_ok_next = 1'h0;
               state_next = S_FUV;
            end
            S_FUV: if (fl_ok) begin
               flag_v_next = FL_RDATA;
               state_next  = S_FUI;
            end
            S_FUI: if (fl_ok) begin
               if (rd_state == 2'h2) begin
                  state_next = S_ERASE;
               end else begin
                  if (rd_state == 2'h3 && !fb_ok_reg) begin
                     fb_ok_next  = 1'h1;
                     fb_blk_next = blk_reg;
                  end
                  if (blk_reg != BLK_LAST) begin
                     blk_next   = ~blk_reg;
                     state_next = S_FUV;
                  end else if (fb_ok_reg || rd_state == 2'h3) begin
                     // No unused block left: recycle the lowest-numbered invalid one
                     blk_next   = fb_ok_reg ? fb_blk_reg : blk_reg;
                     state_next = S_ERASE;
                  end else begin
                     state_next = S_ERR;
                  end
               end
            end
            S_ERASE: if (fl_ok) begin
               state_next = S_MKVAL;
            end
            S_MKVAL: if (fl_ok) begin
               wr_next    = OFF_FIRST;
               state_next = S_RUN;
            end
            S_RUN: if (lvd_s) begin
               state_next = S_SVREC;
            end
            S_SVREC: if (fl_ok) begin
               state_next = S_SVTERM;
            end
            S_SVTERM: if (fl_ok) begin
               state_next = S_CLOSE;
            end
            S_CLOSE: begin
               state_next = S_DONE;
            end
            S_DONE: begin
               state_next = S_DONE;
            end
            S_ERR: begin
               state_next = S_ERR;
            end
            default: begin
               state_next = S_ERR;
            end
         endcase
      end
   end

   // Command and address for the operation of the next state
   logic [1:0]       cmd_next;
   logic [OFF_W-1:0] off_next;
   logic [7:0]       wdata_next;

   always_comb begin
      cmd_next   = FC_READ;
      off_next   = OFF_VALID;
      wdata_next = FLAG_SET;
      case (state_next)
         S_RDV, S_FUV: begin
            off_next = OFF_VALID;
         end
         S_RDI, S_FUI: begin
            off_next = OFF_INVALID;
         end
         S_SCAN: begin
            cmd_next = FC_BLANK;
            off_next = ptr_next;
         end
         S_RDREC: begin
            off_next = ptr_next;
         end
         S_MKINV: begin
            cmd_next = FC_WRITE;
            off_next = OFF_INVALID;
         end
         S_ERASE: begin
            cmd_next = FC_ERASE;
         end
         S_MKVAL: begin
            cmd_next = FC_WRITE;
         end
         S_SVREC: begin
            cmd_next   = FC_WRITE;
            off_next   = wr_next;
            wdata_next = rec_byte;
         end
         S_SVTERM: begin
            cmd_next   = FC_WRITE;
            off_next   = wr_next + 10'h001;
            wdata_next = REC_TERM;
         end
         default: begin
            cmd_next = FC_READ;
         end
      endcase
   end

   // Request drops for one cycle between operations so each ack is unambiguous
   wire req_next = is_flash_op(state_next) & ~fl_done & en_reg;
   wire en_next  = (state_next != S_CLOSE) && (state_next != S_DONE) &&
                   (state_next != S_ERR);

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_reg  <= S_OPEN;
         blk_reg    <= 1'h0;
         flag_v_reg <= FLAG_CLR;
         ptr_reg    <= OFF_LAST;
         wr_reg     <= OFF_FIRST;
         fb_ok_reg  <= 1'h0;
         fb_blk_reg <= 1'h0;
         req_reg    <= 1'h0;
         cmd_reg    <= FC_READ;
         addr_reg   <= DF_BASE;
         wdata_reg  <= FLAG_SET;
         en_reg     <= 1'h0;
      end else begin
         state_reg  <= state_next;
         blk_reg    <= blk_next;
         flag_v_reg <= flag_v_next;
         ptr_reg    <= ptr_next;
         wr_reg     <= wr_next;
         fb_ok_reg  <= fb_ok_next;
         fb_blk_reg <= fb_blk_next;
         req_reg    <= req_next;
         cmd_reg    <= cmd_next;
         addr_reg   <= DF_BASE + FA_W'({blk_next, off_next});
         wdata_reg  <= wdata_next;
         en_reg     <= en_next;
      end
   end

   // ==========================================================
   // Debounce and keypress qualification
   wire deb_end   = deb_busy_reg && (deb_cnt_reg == CNT_W'(DEB_CYC - 1));
   wire key_hit   = (deb_end && !key_n_s) || soft_key_reg;
   wire key_take  = key_hit && (state_reg == S_RUN) && !run_reg;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         deb_busy_reg <= 1'h0;
         deb_cnt_reg  <= '0;
      end else if (key_fall && !deb_busy_reg) begin
         deb_busy_reg <= 1'h1;
         deb_cnt_reg  <= '0;
      end else if (deb_busy_reg) begin
         deb_busy_reg <= ~deb_end;
         deb_cnt_reg  <= deb_cnt_reg + CNT_W'(1);
      end
   end

   // ==========================================================
   // Blink engine; frozen once saving starts so the record matches the lights
   // No toggle on the save edge, else the stored count lags the lights
   wire tick = run_reg && (state_reg == S_RUN) && !ctrl_reg[CTRL_HOLD] && !lvd_s &&
               (blink_cnt_reg == CNT_W'(BLINK_CYC - 1));

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         run_reg       <= 1'h0;
         tgt_reg       <= 1'h0;
         last_tgt_reg  <= 1'h1;
         rem_reg       <= 4'h0;
         ind_a_reg     <= 1'h0;
         ind_b_reg     <= 1'h0;
         blink_cnt_reg <= '0;
      end else if (state_reg == S_ERR) begin
         run_reg   <= 1'h0;
         ind_a_reg <= 1'h1;
         ind_b_reg <= 1'h1;
      end else if (restore) begin
         if ((rec_tgt == TGT_A || rec_tgt == TGT_B) && rec_rem != 4'h0) begin
            run_reg <= 1'h1;
            tgt_reg <= rec_tgt[0];
            rem_reg <= rec_rem;
         end
         last_tgt_reg <= rec_tgt[0];
      end else if (key_take) begin
         run_reg       <= 1'h1;
         tgt_reg       <= ~last_tgt_reg;
         last_tgt_reg  <= ~last_tgt_reg;
         rem_reg       <= 4'(BLINK_TOGGLES);
         blink_cnt_reg <= '0;
      end else if (run_reg && state_reg == S_RUN && !ctrl_reg[CTRL_HOLD]) begin
         blink_cnt_reg <= tick ? '0 : blink_cnt_reg + CNT_W'(1);
         if (tick) begin
            rem_reg <= rem_reg - 4'h1;
            run_reg <= (rem_reg != 4'h1);
            if (tgt_reg)
               ind_b_reg <= ~ind_b_reg;
            else
               ind_a_reg <= ~ind_a_reg;
         end
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         done_reg <= 1'h0;
         stop_reg <= 1'h0;
      end else begin
         done_reg <= done_reg | (state_reg == S_CLOSE);
         stop_reg <= stop_reg | (state_reg == S_DONE) | (state_reg == S_ERR);
      end
   end

   // ==========================================================
   // APB slave, no wait states: ready in the first access cycle
   wire [7:0] rsel     = PADDR[7:0];
   wire       hit      = (PADDR[31:8] == 24'h000000) &&
                         (rsel == REG_CTRL || rsel == REG_STATUS || rsel == REG_WADDR);
   wire       apb_wr   = PSEL & PENABLE & PWRITE & pready_reg & hit & ~pslverr_reg;
   wire       wr_ctrl  = apb_wr && (rsel == REG_CTRL);
   wire [31:0] status_w = {12'h000, state_reg == S_RUN, stop_reg, done_reg,
                           state_reg == S_ERR, 3'h0, last_tgt_reg,
                           3'h0, run_reg, 3'h0, tgt_reg, rem_reg[3:0]};
   wire [31:0] rd_mux  = (rsel == REG_CTRL)   ? {30'h00000000, ctrl_reg} :
                         (rsel == REG_STATUS) ? status_w :
                         (rsel == REG_WADDR)  ? {12'h000, DF_BASE + FA_W'({blk_reg, wr_reg})} :
                                                32'h00000000;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         pready_reg   <= 1'h0;
         pslverr_reg  <= 1'h0;
         prdata_reg   <= 32'h00000000;
         ctrl_reg     <= CTRL_RST;
         soft_key_reg <= 1'h0;
      end else begin
         pready_reg   <= PSEL & ~PENABLE;
         pslverr_reg  <= PSEL & ~PENABLE & ~hit;
         prdata_reg   <= (PSEL & ~PENABLE & ~PWRITE) ? rd_mux : 32'h00000000;
         soft_key_reg <= wr_ctrl & PWDATA[CTRL_KEY];
         if (wr_ctrl)
            ctrl_reg <= {PWDATA[CTRL_HOLD], 1'h0};
      end
   end

   // ==========================================================
   // Outputs
   assign IND_A     = ind_a_reg;
   assign IND_B     = ind_b_reg;
   assign SAVE_DONE = done_reg;
   assign STOP_MODE = stop_reg;
   assign FL_EN     = en_reg;
   assign FL_REQ    = req_reg;
   assign FL_CMD    = cmd_reg;
   assign FL_ADDR   = addr_reg;
   assign FL_WDATA  = wdata_reg;
   assign PRDATA    = prdata_reg;
   assign PREADY    = pready_reg;
   assign PSLVERR   = pslverr_reg;

endmodule

// ===== tb/pfsl_sva.sv
// Port checker for the power-fail state logger
`timescale 1ns/1ps
module pfsl_sva
   import pfsl_pkg::*;
#(
   parameter int unsigned BLINK_CYC = 20
) (
   input wire logic        CLK,
   input wire logic        RSTN,
   input wire logic        IND_A,
   input wire logic        IND_B,
   input wire logic        SAVE_DONE,
   input wire logic        STOP_MODE,
   input wire logic        FL_EN,
   input wire logic        FL_REQ,
   input wire logic [1:0]  FL_CMD,
   input wire logic [19:0] FL_ADDR,
   input wire logic [7:0]  FL_WDATA,
   input wire logic        FL_ACK,
   input wire logic        FL_ERR,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic [31:0] PADDR,
   input wire logic        PREADY,
   input wire logic        PSLVERR
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   // ==========================================================
   // Cycles since an indicator changed; saturates so it never wraps
   logic [CNT_W-1:0] gap_reg;
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         gap_reg <= '0;
      end else if ($changed(IND_A) || $changed(IND_B)) begin
         gap_reg <= '0;
      end else if (gap_reg != '1) begin
         gap_reg <= gap_reg + CNT_W'(1);
      end
   end
   // ==========================================================
   // Assertions
   req_open_a: assert property (FL_REQ |-> FL_EN)
      else $error("flash request while access closed");
   req_hold_a: assert property (FL_REQ && !FL_ACK |=> FL_REQ && $stable(FL_ADDR))
      else $error("flash request dropped or moved before ack");
   flag_set_a: assert property (FL_REQ && FL_CMD == FC_WRITE && FL_ADDR[9:1] == 9'h0
      |-> FL_WDATA == FLAG_SET) else $error("flag byte written with wrong value");
   addr_map_a: assert property (FL_REQ |-> FL_ADDR[19:11] == DF_BASE[19:11])
      else $error("flash address outside data area");
   term_next_a: assert property (FL_REQ && FL_ACK && !FL_ERR && FL_CMD == FC_WRITE
      && !FL_ADDR[0] && FL_ADDR[9:1] != 9'h0 |-> ##2 FL_REQ && FL_CMD == FC_WRITE
      && FL_WDATA == REC_TERM && FL_ADDR == $past(FL_ADDR, 2) + 20'h1)
      else $error("record not followed by terminator");
   no_erase_a: assert property (FL_REQ && FL_CMD == FC_ERASE |-> !SAVE_DONE && !STOP_MODE)
      else $error("erase outside preparation");
   save_seq_a: assert property ($rose(SAVE_DONE) |-> !FL_EN ##1 STOP_MODE)
      else $error("save completion order wrong");
   err_stop_a: assert property (FL_REQ && FL_ACK && FL_ERR
      |-> ##[1:3] IND_A && IND_B && STOP_MODE && !FL_EN) else $error("flash error not handled");
   blink_gap_a: assert property (($changed(IND_A) || $changed(IND_B)) && !(IND_A && IND_B)
      |-> gap_reg >= BLINK_CYC - 1) else $error("blink interval too short");
   apb_resp_a: assert property (PSEL && PENABLE |-> PREADY
      && PSLVERR == !(PADDR inside {32'h0, 32'h4, 32'h8})) else $error("bad register response");
endmodule

// ===== tb/pfsl_flash_model.sv
// Behavioural data flash array on the far side of the logger
`timescale 1ns/1ps
module pfsl_flash_model
   import pfsl_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RSTN,
   input  wire logic        FL_EN,
   input  wire logic        FL_REQ,
   input  wire logic [1:0]  FL_CMD,
   input  wire logic [19:0] FL_ADDR,
   input  wire logic [7:0]  FL_WDATA,
   input  wire logic [1:0]  lat,
   input  wire logic        err_inj,
   output logic             FL_ACK,
   output logic [7:0]       FL_RDATA,
   output logic             FL_BLANK,
   output logic             FL_ERR,
   output logic [7:0]       viol
);
   // Array keeps its contents across resets, like real flash
   logic [7:0]  mem [0:2047];
   logic        wr  [0:2047];
   logic [1:0]  cnt;
   logic        done;
   logic [10:0] a;
   assign a = FL_ADDR[10:0];
   initial begin
      for (int i = 0; i < 2048; i++) begin
         mem[i] = 8'hff;
         wr[i]  = 1'b0;
      end
      {FL_ACK, FL_RDATA, FL_BLANK, FL_ERR, viol} = '0;
   end
   always @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         FL_ACK <= 1'b0;
         done   <= 1'b0;
         cnt    <= 2'h0;
      end else begin
         // Outside an ack the answer lines change every cycle
         FL_ACK   <= 1'b0;
         FL_RDATA <= ~FL_RDATA;
         FL_BLANK <= ~FL_BLANK;
         FL_ERR   <= ~FL_ERR;
         if (!FL_REQ) begin
            done <= 1'b0;
            cnt  <= 2'h0;
         end else if (!done && cnt != lat) begin
            cnt <= cnt + 2'h1;
         end else if (!done) begin
            done   <= 1'b1;
            FL_ACK <= 1'b1;
            FL_ERR <= err_inj;
            if (!FL_EN || (FL_CMD == FC_WRITE && wr[a])) viol <= viol + 8'h1;
            case (FL_CMD)
               FC_READ:  FL_RDATA <= mem[a];
               FC_WRITE: begin
                  mem[a] <= FL_WDATA;
                  wr[a]  <= 1'b1;
               end
               FC_BLANK: FL_BLANK <= !wr[a] && !wr[a + 11'h1];
               default: for (int i = 0; i < 1024; i++) begin
                  mem[{a[10], i[9:0]}] <= 8'hff;
                  wr[{a[10], i[9:0]}]  <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ===== tb/tb_top.sv
// Self-checking bench for the power-fail state logger
`timescale 1ns/1ps
module tb_top;
   import pfsl_pkg::*;
   // Short counts keep the run small
   localparam int unsigned BC = 20;
   localparam int unsigned DC = 5;
   logic        CLK = 1'b0, RSTN = 1'b0, KEY_N = 1'b1, LOW_VOLT = 1'b0;
   logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, err_inj = 1'b0, pa = 1'b0, se;
   logic        IND_A, IND_B, SAVE_DONE, STOP_MODE, FL_EN, FL_REQ, FL_ACK, FL_BLANK, FL_ERR;
   logic        PREADY, PSLVERR, pb = 1'b0;
   logic [1:0]  FL_CMD, lat = 2'h0;
   logic [7:0]  FL_WDATA, FL_RDATA, viol;
   logic [19:0] FL_ADDR;
   logic [31:0] PADDR = 32'h0, PWDATA = 32'h0, PRDATA, rd, seed = 32'hfa4e;
   int          err_total, total_checks, na, nb, rem, i;
   pfsl_top #(.BLINK_CYC(BC), .DEB_CYC(DC)) u_dut (.*);
   pfsl_flash_model u_fl (.*);
   initial forever #10 CLK = ~CLK;
   function void xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
   endfunction
   // Random flash latency, and counts of indicator changes
   always @(posedge CLK) begin
      xs();
      lat <= seed[1:0];
      pa  <= IND_A;
      if (IND_A !== pa) na <= na + 1;
      pb  <= IND_B;
      if (IND_B !== pb) nb <= nb + 1;
   end
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task timeout;
      err_total++;
      $display("MISMATCH wait expired");
      stop_test();
   endtask
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      @(posedge CLK);
      PSEL   <= 1'b1;
      PWRITE <= w;
      PADDR  <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge CLK);
         if (PREADY === 1'b1) break;
      end
      if (k == 20) timeout();
      rd = PRDATA;
      se = PSLVERR;
      PSEL    <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task st;
      apb(1'b0, {24'h0, REG_STATUS}, 32'h0);
   endtask
   task poll(input int b, input logic v);
      int k;
      for (k = 0; k < 2000; k++) begin
         st();
         if (rd[b] === v) break;
      end
      if (k == 2000) timeout();
   endtask
   task rst;
      RSTN <= 1'b0;
      repeat (16) @(posedge CLK);
      RSTN <= 1'b1;
   endtask
   task press;
      KEY_N <= 1'b0;
      repeat (DC + 6 + seed[2:0]) @(posedge CLK);
      KEY_N <= 1'b1;
      @(posedge CLK);
   endtask
   initial begin
      err_total = 0;
      total_checks = 0;
      rst();
      poll(19, 1'b1);
      chk("idle", rd[8], 1'b0);
      chk("flags", {u_fl.mem[0], u_fl.mem[1]}, 16'h00ff);
      apb(1'b0, {24'h0, REG_WADDR}, 32'h0);
      chk("waddr", rd, 32'hf1002);
      apb(1'b0, 32'h0c, 32'h0);
      chk("unmapped", {se, rd}, {1'b1, 32'h0});
      KEY_N <= 1'b0;
      repeat (3) @(posedge CLK);
      KEY_N <= 1'b1;
      repeat (DC + 8) @(posedge CLK);
      st();
      chk("glitch", rd[8], 1'b0);
      na = 0;
      nb = 0;
      press();
      st();
      chk("start a", {rd[8], rd[4]}, 2'b10);
      press();
      poll(8, 1'b0);
      chk("toggles", na, 10);
      chk("last a", {IND_A, rd[12]}, 2'b00);
      apb(1'b1, {24'h0, REG_CTRL}, 32'h1);
      st();
      chk("start b", {rd[8], rd[4]}, 2'b11);
      repeat (3 * BC + 5) @(posedge CLK);
      apb(1'b1, {24'h0, REG_CTRL}, 32'h2);
      st();
      rem = rd[3:0];
      chk("remaining", rem, BLINK_TOGGLES - nb);
      LOW_VOLT <= 1'b1;
      poll(18, 1'b1);
      chk("saved", {SAVE_DONE, FL_EN}, 2'b10);
      chk("record", {u_fl.mem[2], u_fl.mem[3]}, {4'h1, rem[3:0], REC_TERM});
      LOW_VOLT <= 1'b0;
      rst();
      poll(19, 1'b1);
      chk("resume", {rd[8], rd[4], rd[3:0]}, {2'b11, rem[3:0]});
      apb(1'b0, {24'h0, REG_WADDR}, 32'h0);
      chk("waddr2", rd, 32'hf1004);
      // Fill block 0 so the next start must switch blocks
      RSTN <= 1'b0;
      @(posedge CLK);
      for (i = 2; i < 1024; i++) begin
         u_fl.mem[i] = 8'h5a;
         u_fl.wr[i]  = 1'b1;
      end
      rst();
      poll(19, 1'b1);
      chk("switch", {u_fl.mem[1], u_fl.mem[1024]}, 16'h0000);
      apb(1'b0, {24'h0, REG_WADDR}, 32'h0);
      chk("waddr3", rd, 32'hf1402);
      chk("overwrite", viol, 8'h0);
      err_inj <= 1'b1;
      rst();
      poll(18, 1'b1);
      chk("error", {IND_A, IND_B, FL_EN, rd[16]}, 4'b1101);
      stop_test();
   end
endmodule
bind pfsl_top pfsl_sva #(.BLINK_CYC(BLINK_CYC)) u_sva (.*);
